// [hw/asp_top.sv]
`timescale 1ns/1ps
// Functional notes
// - Fetching begins at start address.
// - Length counts bytes to consume.
// - Sample rate is frequency register in hertz.
// - Format selects linear, mu-law or adaptive.
// - Decode 8-bit linear, mu-law, 4-bit adaptive.
// - Adaptive: low nibble first, then high.
// - Loop zero plays once, one repeats.
// - Any play write with nonzero length starts playback.
// - Play reads one while playing.
// - Fetch pointer readable, tracks clip progress.
// - Notes 21..108 map equal-tempered, 69 is 440.
// - Note number from sound-select upper byte.
// - Audio leaves on one PWM pin.
// - Output mixes synthesizer and playback.
module asp_top #(
   parameter int AW = 20  // RAM address width
) (
   input  wire logic          MCLK,
   input  wire logic          RST_N,
   input  wire logic [7:0]    ADDR,
   input  wire logic [31:0]   WDATA,
   input  wire logic          WR,
   input  wire logic          RD,
   output logic      [31:0]   RDATA,
   output logic      [AW-1:0] MEM_ADDR,
   output logic               MEM_RD,
   input  wire logic [7:0]    MEM_RDATA,
   input  wire logic [7:0]    SYNTH_SAMPLE,
   output logic               AUDIO,
   output logic               IRQ
);
   import asp_pkg::*;

   // Refuse widths the 32-bit bus cannot carry
   if (AW < 8 || AW > 32) begin : g_bad_aw
      $error("AW must lie between 8 and 32");
   end

   // Deci-hertz pitch of the top octave, from A upward
   localparam logic [16:0] OCT_TAB [0:11] = '{
      17'd35200, 17'd37293, 17'd39511, 17'd41860, 17'd44349, 17'd46986,
      17'd49780, 17'd52740, 17'd55875, 17'd59199, 17'd62719, 17'd66448};

   // Playback sequencer states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,  // Nothing playing
      ST_FETCH = 2'b01,  // Read strobe out
      ST_WAIT  = 2'b10,  // Byte arrives
      ST_HOLD  = 2'b11   // Waiting for sample tick
   } asp_state_t;

   // Whole block state
   typedef struct packed {
      asp_state_t          st;       // Sequencer
      logic [AW-1:0]       start;    // Clip start address
      logic [AW-1:0]       length;   // Clip length, bytes
      logic [15:0]         freq;     // Sample rate, Hz
      logic [1:0]          fmt;      // Format code
      logic                loop;     // Repeat clip
      logic [7:0]          vol;      // Playback volume
      logic [15:0]         sound;    // Sound select
      logic [IRQ_BITS-1:0] irq_st;   // Sticky events
      logic [IRQ_BITS-1:0] irq_msk;  // Event enables
      logic [AW-1:0]       ptr;      // Next fetch address
      logic [AW-1:0]       remain;   // Bytes left
      logic [23:0]         acc;      // Rate accumulator
      logic [7:0]          code;     // Held byte
      logic                nib_hi;   // Second nibble due
      logic                last;     // Held byte ends clip
      logic                playing;  // Play status
      logic signed [15:0]  smp;      // Scaled playback
      logic [7:0]          pwm_cnt;  // PWM ramp
      logic [7:0]          pwm_lvl;  // PWM duty
      logic [31:0]         rdata;    // Read answer
   } asp_st_t;

   asp_st_t q, n;
   asp_dec_if dec ();

   logic                tick;      // One sample period elapsed
   logic [24:0]         acc_sum;   // Accumulator plus rate
   logic                wr_play;   // Trigger write
   logic [IRQ_BITS-1:0] ev;        // Events this cycle
   logic [IRQ_BITS-1:0] clr;       // Software clears
   logic [7:0]          note;      // Clamped note number
   logic [7:0]          tnote;     // Note shifted to octave base
   logic [3:0]          oct;       // Octave of note
   logic [3:0]          semi;      // Semitone within octave
   logic [16:0]         note_freq; // Pitch, tenths of Hz
   logic signed [24:0]  prod;      // Sample times volume
   logic signed [16:0]  mix;       // Summed sources
   logic signed [15:0]  mix_sat;   // Saturated mix

   asp_decoder u_dec (
      .MCLK  (MCLK),
      .RST_N (RST_N),
      .d     (dec.dec)
   );

   // Pitch map from the sound-select high byte
   always_comb begin
      note = q.sound[15:8];
      if (note < NOTE_LO) note = NOTE_LO;
      if (note > NOTE_HI) note = NOTE_HI;
      tnote = note + NOTE_OFS;                           // A falls on octave start
      oct   = 4'(tnote / SEMIS);
      semi  = 4'(tnote % SEMIS);
      note_freq = OCT_TAB[semi] >> (TOP_OCT - oct);     // 69 gives 4400
   end

   // Decoder hookup
   assign dec.fmt     = q.fmt;
   assign dec.code    = q.code;
   assign dec.nib_hi  = q.nib_hi;
   assign dec.step    = (q.st == ST_HOLD) && tick;
   assign dec.restart = wr_play;

   // Mixing of playback and synthesizer
   always_comb begin
      prod = dec.pcm * $signed({1'b0, q.vol});          // 0 mutes
      mix  = 17'(q.smp) + 17'($signed({SYNTH_SAMPLE, 8'h00}));
      if (mix > 17'sd32767) begin
         mix_sat = 16'sh7FFF;
      end else if (mix < -17'sd32768) begin
         mix_sat = 16'sh8000;
      end else begin
         mix_sat = mix[15:0];
      end
   end

   assign wr_play = WR && ADDR == OFS_PLAY;              // Data ignored
   assign acc_sum = {1'b0, q.acc} + {9'h000, q.freq};

   // Next-state logic
   always_comb begin
      n    = q;
      ev   = '0;
      clr  = '0;
      tick = 1'b0;
      // Sample-rate divider, exact on average
      if (q.playing) begin
         if (acc_sum >= {1'b0, CLK_HZ}) begin
            n.acc = 24'(acc_sum - {1'b0, CLK_HZ});
            tick  = 1'b1;
         end else begin
            n.acc = acc_sum[23:0];
         end
      end else begin
         n.acc = '0;
      end
      // Register writes
      if (WR) begin
         case (ADDR)
            OFS_START:    n.start   = WDATA[AW-1:0];
            OFS_LENGTH:   n.length  = WDATA[AW-1:0];
            OFS_FREQ:     n.freq    = WDATA[15:0];
            OFS_FORMAT:   n.fmt     = WDATA[1:0];
            OFS_LOOP:     n.loop    = WDATA[0];
            OFS_VOLUME:   n.vol     = WDATA[7:0];
            OFS_SOUND:    n.sound   = WDATA[15:0];
            OFS_IRQ_STAT: clr       = WDATA[IRQ_BITS-1:0];
            OFS_IRQ_MASK: n.irq_msk = WDATA[IRQ_BITS-1:0];
            default:      n.irq_msk = q.irq_msk;       // Others ignored
         endcase
      end
      // Register reads, answer in the next cycle only
      n.rdata = '0;
      if (RD) begin
         case (ADDR)
            OFS_START:    n.rdata = 32'(q.start);
            OFS_LENGTH:   n.rdata = 32'(q.length);
            OFS_FREQ:     n.rdata = {16'h0000, q.freq};
            OFS_FORMAT:   n.rdata = {30'h0, q.fmt};
            OFS_LOOP:     n.rdata = {31'h0, q.loop};
            OFS_PLAY:     n.rdata = {31'h0, q.playing};
            OFS_VOLUME:   n.rdata = {24'h0, q.vol};
            OFS_FETCHPTR: n.rdata = 32'(q.ptr);
            OFS_SOUND:    n.rdata = {16'h0000, q.sound};
            OFS_NOTEFREQ: n.rdata = {15'h0, note_freq};
            OFS_IRQ_STAT: n.rdata = 32'(q.irq_st);
            OFS_IRQ_MASK: n.rdata = 32'(q.irq_msk);
            default:      n.rdata = '0;                      // Unmapped reads zero
         endcase
      end
      // Playback sequencer
      case (q.st)
         ST_IDLE: begin
            n.smp = '0;
         end
         ST_FETCH: begin
            n.st = ST_WAIT;                                  // Strobe is out now
         end
         ST_WAIT: begin
            n.code   = MEM_RDATA;
            n.nib_hi = 1'b0;
            n.st     = ST_HOLD;
            n.last   = 1'b0;
            if (q.remain == AW'(1)) begin                    // Byte count spent
               if (q.loop) begin
                  n.ptr    = q.start;                        // Wrap, fetch goes on
                  n.remain = q.length;
                  ev[IRQ_WRAP_BIT] = 1'b1;
               end else begin
                  n.ptr    = q.ptr + AW'(1);
                  n.remain = '0;
                  n.last   = 1'b1;                           // Play once
               end
            end else begin
               n.ptr    = q.ptr + AW'(1);
               n.remain = q.remain - AW'(1);
            end
         end
         ST_HOLD: begin
            if (tick) begin
               n.smp = prod[23:8];
               if (q.fmt == FMT_ADPCM && !q.nib_hi) begin
                  n.nib_hi = 1'b1;                           // Then high nibble
               end else if (q.last) begin
                  n.st      = ST_IDLE;
                  n.playing = 1'b0;
                  ev[IRQ_DONE_BIT] = 1'b1;
               end else begin
                  n.st = ST_FETCH;   // Prefetch fits well inside one period
               end
            end
         end
         default: n.st = ST_IDLE;
      endcase
      // Trigger overrides whatever is going on
      if (wr_play) begin
         n.ptr    = q.start;
         n.remain = q.length;
         n.acc    = '0;
         n.nib_hi = 1'b0;
         n.last   = 1'b0;
         ev[IRQ_DONE_BIT] = 1'b0;
         if (q.length == '0) begin
            n.st      = ST_IDLE;                             // Empty clip ends at once
            n.playing = 1'b0;
            ev[IRQ_DONE_BIT] = 1'b1;
         end else begin
            n.st      = ST_FETCH;
            n.playing = 1'b1;
         end
      end
      // Sticky events, a new event beats a clear
      n.irq_st = (q.irq_st & ~clr) | ev;
      // PWM duty latched at ramp start to avoid glitches
      n.pwm_cnt = q.pwm_cnt + 8'h01;
      if (q.pwm_cnt == 8'hFF) n.pwm_lvl = mix_sat[15:8] ^ 8'h80;
   end

   // State register
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         q         <= '0;
         q.st      <= ST_IDLE;
         q.freq    <= RST_FREQ;
         q.vol     <= RST_VOLUME;
         q.sound   <= RST_SOUND;
         q.pwm_lvl <= 8'h80;
      end else begin
         q <= n;
      end
   end

   // Outputs
   assign RDATA    = q.rdata;
   assign MEM_ADDR = q.ptr;                // Fetch address from flops
   assign MEM_RD   = q.st == ST_FETCH;
   assign AUDIO    = q.pwm_cnt < q.pwm_lvl;  // Single PWM pin
   assign IRQ      = |(q.irq_st & q.irq_msk);
endmodule

// [hw/asp_pkg.sv]
package asp_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_START    = 8'h00;
   localparam logic [7:0] OFS_LENGTH   = 8'h04;
   localparam logic [7:0] OFS_FREQ     = 8'h08;
   localparam logic [7:0] OFS_FORMAT   = 8'h0C;
   localparam logic [7:0] OFS_LOOP     = 8'h10;
   localparam logic [7:0] OFS_PLAY     = 8'h14;
   localparam logic [7:0] OFS_VOLUME   = 8'h18;
   localparam logic [7:0] OFS_FETCHPTR = 8'h1C;
   localparam logic [7:0] OFS_SOUND    = 8'h20;
   localparam logic [7:0] OFS_NOTEFREQ = 8'h24;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
   // Format codes
   localparam logic [1:0] FMT_LINEAR = 2'h0;
   localparam logic [1:0] FMT_MULAW  = 2'h1;
   localparam logic [1:0] FMT_ADPCM  = 2'h2;
   // Interrupt status bit positions
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_WRAP_BIT = 1;
   localparam int IRQ_BITS     = 2;
   // Reset values
   localparam logic [15:0] RST_FREQ   = 16'h1F40;
   localparam logic [7:0]  RST_VOLUME = 8'hFF;
   localparam logic [15:0] RST_SOUND  = 16'h0000;
   // System clock rate, in hertz
   localparam logic [23:0] CLK_HZ = 24'h989680;
   // Note range of the pitch map
   localparam logic [7:0] NOTE_LO = 8'h15;
   localparam logic [7:0] NOTE_HI = 8'h6C;
   localparam logic [7:0] NOTE_OFS = 8'h03;
   localparam logic [3:0] TOP_OCT  = 4'h9;
   localparam logic [7:0] SEMIS    = 8'h0C;
endpackage

// [hw/asp_dec_if.sv]
`timescale 1ns/1ps
interface asp_dec_if;
   logic [1:0]         fmt;      // Selected decoder
   logic [7:0]         code;     // Current sample byte
   logic               nib_hi;   // High nibble selected
   logic               step;     // Sample consumed
   logic               restart;  // Clear adaptive state
   logic signed [15:0] pcm;      // Decoded sample
   modport ctl (output fmt, code, nib_hi, step, restart, input pcm);
   modport dec (input fmt, code, nib_hi, step, restart, output pcm);
endinterface

// [hw/asp_decoder.sv]
`timescale 1ns/1ps
module asp_decoder (
   input  wire logic MCLK,
   input  wire logic RST_N,
   asp_dec_if.dec    d
);
   import asp_pkg::*;

   // Step sizes of the adaptive coder
   localparam logic [14:0] STEP_TAB [0:88] = '{
      15'd7, 15'd8, 15'd9, 15'd10, 15'd11, 15'd12, 15'd13, 15'd14, 15'd16, 15'd17,
      15'd19, 15'd21, 15'd23, 15'd25, 15'd28, 15'd31, 15'd34, 15'd37, 15'd41, 15'd45,
      15'd50, 15'd55, 15'd60, 15'd66, 15'd73, 15'd80, 15'd88, 15'd97, 15'd107, 15'd118,
      15'd130, 15'd143, 15'd157, 15'd173, 15'd190, 15'd209, 15'd230, 15'd253, 15'd279,
      15'd307, 15'd337, 15'd371, 15'd408, 15'd449, 15'd494, 15'd544, 15'd598, 15'd658,
      15'd724, 15'd796, 15'd876, 15'd963, 15'd1060, 15'd1166, 15'd1282, 15'd1411,
      15'd1552, 15'd1707, 15'd1878, 15'd2066, 15'd2272, 15'd2499, 15'd2749, 15'd3024,
      15'd3327, 15'd3660, 15'd4026, 15'd4428, 15'd4871, 15'd5358, 15'd5894, 15'd6484,
      15'd7132, 15'd7845, 15'd8630, 15'd9493, 15'd10442, 15'd11487, 15'd12635,
      15'd13899, 15'd15289, 15'd16818, 15'd18500, 15'd20350, 15'd22385, 15'd24623,
      15'd27086, 15'd29794, 15'd32767};

   // Adaptive predictor state
   typedef struct packed {
      logic signed [15:0] pred;  // Last predicted value
      logic [6:0]         idx;   // Step table index
   } asp_dec_st_t;

   asp_dec_st_t q, n;
   logic [3:0]         nib;      // Active nibble
   logic [14:0]        stp;      // Current step
   logic [16:0]        dif;      // Magnitude of change
   logic signed [17:0] sum;      // Unclamped prediction
   logic signed [7:0]  ix;       // Unclamped index
   logic [7:0]         mu;       // Inverted mu-law byte
   logic [15:0]        mag;      // Mu-law magnitude

   // Decode all three formats, pick one
   always_comb begin
      n   = q;
      nib = d.nib_hi ? d.code[7:4] : d.code[3:0];  // Low nibble first
      stp = STEP_TAB[q.idx];
      dif = {5'h00, stp[14:3]};
      if (nib[0]) dif = dif + {4'h0, stp[14:2]};
      if (nib[1]) dif = dif + {3'h0, stp[14:1]};
      if (nib[2]) dif = dif + {2'h0, stp};
      sum = nib[3] ? 18'(q.pred) - $signed({1'b0, dif}) : 18'(q.pred) + $signed({1'b0, dif});
      if (sum > 18'sd32767) sum = 18'sd32767;            // Clamp high
      if (sum < -18'sd32768) sum = -18'sd32768;          // Clamp low
      ix = $signed({1'b0, q.idx}) + (nib[2] ? 8'(signed'({1'b0, nib[1:0]}) * 2 + 2)
                                          : -8'sd1);
      if (ix < 0) ix = 8'sd0;
      if (ix > 8'sd88) ix = 8'sd88;
      // Mu-law: segment and mantissa of the inverted byte
      mu  = ~d.code;
      mag = ((({8'h00, 1'b0, mu[3:0], 3'h0}) + 16'h0084) << mu[6:4]) - 16'h0084;
      case (d.fmt)
         FMT_LINEAR: d.pcm = {d.code, 8'h00};
         FMT_MULAW:  d.pcm = mu[7] ? -$signed(mag) : $signed(mag);
         FMT_ADPCM:  d.pcm = sum[15:0];
         default:    d.pcm = 16'sh0000;
      endcase
      if (d.step && d.fmt == FMT_ADPCM) begin
         n.pred = sum[15:0];
         n.idx  = ix[6:0];
      end
      if (d.restart) begin
         n.pred = '0;
         n.idx  = '0;
      end
   end

   // Predictor register
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
endmodule

// [testbench/asp_ram_model.sv]
`timescale 1ns/1ps
// Sample RAM behind the fetch port
module asp_ram_model #(
   parameter int AW = 20  // Address width
) (
   input  wire logic          MCLK,
   input  wire logic          MEM_RD,
   input  wire logic [AW-1:0] MEM_ADDR,
   output logic      [7:0]    MEM_RDATA
);
   logic [7:0] mem [0:4095];  // Bench loads this directly
   initial MEM_RDATA = 8'h00;
   // One-cycle answer; otherwise toggle so a late capture shows wrong data
   always @(posedge MCLK) begin
      if (MEM_RD) begin
         MEM_RDATA <= mem[MEM_ADDR[11:0]];
      end else begin
         MEM_RDATA <= ~MEM_RDATA;
      end
   end
endmodule

// [testbench/asp_top_asserts.sv]
`timescale 1ns/1ps
// Port-level checks of the playback block
module asp_top_asserts
   import asp_pkg::*;
#(
   parameter int AW = 20  // Address width
) (
   input wire logic          MCLK,
   input wire logic          RST_N,
   input wire logic [7:0]    ADDR,
   input wire logic [31:0]   WDATA,
   input wire logic          WR,
   input wire logic          RD,
   input wire logic [31:0]   RDATA,
   input wire logic [AW-1:0] MEM_ADDR,
   input wire logic          MEM_RD,
   input wire logic [7:0]    MEM_RDATA,
   input wire logic [7:0]    SYNTH_SAMPLE,
   input wire logic          AUDIO,
   input wire logic          IRQ
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   logic [AW-1:0] start_q;  // Shadow of start address
   logic [AW-1:0] len_q;    // Shadow of length
   logic [7:0]    gap_q;    // Cycles since last fetch or play write, saturating
   wire           pw = WR && ADDR == OFS_PLAY;
   // Shadows follow host writes at the same edge as the block
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         start_q <= '0;
         len_q   <= '0;
         gap_q   <= 8'h00;
      end else begin
         if (WR && ADDR == OFS_START) start_q <= WDATA[AW-1:0];
         if (WR && ADDR == OFS_LENGTH) len_q <= WDATA[AW-1:0];
         gap_q <= (MEM_RD || pw) ? 8'h00 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
      end
   end
   sequence s_fetch;
      MEM_RD ##1 1'b1;
   endsequence
   sequence s_trigger;
      pw && len_q != '0;
   endsequence
   a_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
      else $error("read data not zero outside read answer");
   a_fetch_pulse: assert property (MEM_RD |=> !MEM_RD)
      else $error("fetch strobe longer than one cycle");
   a_addr_hold: assert property (MEM_RD |=> $stable(MEM_ADDR))
      else $error("fetch address moved before capture");
   a_trig_fetch: assert property (s_trigger |=> MEM_RD && MEM_ADDR == start_q)
      else $error("trigger did not fetch from start address");
   a_ptr_step: assert property (s_fetch |=>
      (MEM_ADDR == $past(MEM_ADDR, 2) + 1'b1) || (MEM_ADDR == start_q))
      else $error("pointer neither advanced nor wrapped");
   // Fastest rate is one tick per 152 to 153 cycles; retriggers excepted
   a_fetch_rate: assert property (MEM_RD && !$past(pw) |-> gap_q >= 8'h64)
      else $error("fetches closer than the sample rate allows");
   a_play_bit: assert property (RD && ADDR == OFS_PLAY |=> RDATA[31:1] == 31'h0)
      else $error("play status wider than one bit");
   a_unmapped_zero: assert property (RD && ADDR > OFS_IRQ_MASK |=> RDATA == 32'h0)
      else $error("unmapped read returned data");
endmodule
bind asp_top asp_top_asserts #(.AW(AW)) u_chk (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
   .MEM_RDATA(MEM_RDATA), .SYNTH_SAMPLE(SYNTH_SAMPLE), .AUDIO(AUDIO), .IRQ(IRQ));

// [testbench/tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); num_errors++; end end
module tb;
   import asp_pkg::*;
   localparam int AW = 20;
   logic          MCLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0;
   logic [7:0]    ADDR = 8'h00, SYNTH_SAMPLE = 8'h00, MEM_RDATA;
   logic [31:0]   WDATA = 32'h0, RDATA, rv, d;
   logic [AW-1:0] MEM_ADDR, base;
   logic          MEM_RD, AUDIO, IRQ;
   logic [31:0]   seed = 32'h00014108;  // Fixed start of the random stream
   logic [AW-1:0] fetched[$];           // Fetch addresses seen
   int            ft[$];                // Fetch cycle numbers
   int            cyc = 0, num_errors = 0, samples_checked = 0, highs;
   logic [7:0]    notes[8] = '{8'h00, 8'h15, 8'h21, 8'h39, 8'h45, 8'h51, 8'h6C, 8'hC8};
   always #50 MCLK = ~MCLK;
   // Record every fetch the block issues
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (MEM_RD === 1'b1) begin
         fetched.push_back(MEM_ADDR);
         ft.push_back(cyc);
      end
   end
   asp_top #(.AW(AW)) DUT (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA),
      .SYNTH_SAMPLE(SYNTH_SAMPLE), .AUDIO(AUDIO), .IRQ(IRQ));
   asp_ram_model #(.AW(AW)) ram (.MCLK(MCLK), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
      .MEM_RDATA(MEM_RDATA));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Pitch in tenths of hertz, after clamping to the table ends
   function automatic logic [31:0] note_exp(input logic [7:0] n);
      case ((n < 8'h15) ? 8'h15 : ((n > 8'h6C) ? 8'h6C : n))
         8'h15: return 32'd275;
         8'h21: return 32'd550;
         8'h39: return 32'd2200;
         8'h45: return 32'd4400;
         8'h51: return 32'd8800;
         default: return 32'd41860;
      endcase
   endfunction
   task automatic give_verdict();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask
   // Read answer stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 v = RDATA;
   endtask
   task automatic settle();
      repeat (2) @(posedge MCLK);
      #1;
   endtask
   task automatic clip(input int n, input logic [1:0] f, input logic lp);
      wr(OFS_START, 32'(base));
      wr(OFS_LENGTH, 32'(n));
      wr(OFS_FORMAT, {30'h0, f});
      wr(OFS_LOOP, {31'h0, lp});
      fetched.delete();
      ft.delete();
      wr(OFS_PLAY, xs());
   endtask
   // Bounded poll of the play flag; a hang ends the run
   task automatic wait_idle();
      for (int i = 0; i < 3000; i++) begin
         rd(OFS_PLAY, rv);
         if (rv === 32'h0) return;
      end
      num_errors++;
      give_verdict();
   endtask
   initial begin
      repeat (2) @(posedge MCLK);
      RST_N <= 1'b1;
      rd(OFS_FREQ, rv); `CHK("freq", 32'h00001F40, rv)
      rd(OFS_VOLUME, rv); `CHK("volume", 32'h000000FF, rv)
      rd(OFS_PLAY, rv); `CHK("idle", 32'h0, rv)
      rd(8'h30, rv); `CHK("unmapped", 32'h0, rv)
      // Random readback; the pointer ignores writes
      for (int i = 0; i < 6; i++) begin
         d = xs();
         wr(OFS_START, d); rd(OFS_START, rv); `CHK("start", {12'h000, d[19:0]}, rv)
         wr(OFS_FETCHPTR, d); rd(OFS_FETCHPTR, rv); `CHK("ptr ro", 32'h0, rv)
      end
      // Note in the upper byte, random effect code below it
      for (int i = 0; i < 8; i++) begin
         d = xs();
         wr(OFS_SOUND, {16'h0000, notes[i], d[7:0]});
         rd(OFS_NOTEFREQ, rv); `CHK("pitch", note_exp(notes[i]), rv)
      end
      for (int i = 0; i < 4096; i++) ram.mem[i] = 8'(xs());
      wr(OFS_FREQ, 32'h0000BB80);
      wr(OFS_IRQ_MASK, 32'h1);
      // Each decoder: fetch order, count and pace from the rate
      for (int f = 0; f < 3; f++) begin
         d = xs();
         base = {8'h00, d[11:4], 4'h0};
         clip(3, f[1:0], 1'b0);
         rd(OFS_PLAY, rv); `CHK("busy", 32'h1, rv)
         wait_idle();
         `CHK("count", 3, fetched.size())
         for (int i = 0; i < 3; i++) `CHK("addr", base + AW'(i), fetched[i])
         highs = (f == 2) ? 2 : 1;
         `CHK("pace", 1'b1, (ft[1] - ft[0]) inside {[208 * highs:209 * highs]})
         settle(); `CHK("irq done", 1'b1, IRQ)
         rd(OFS_IRQ_STAT, rv); `CHK("status", 32'h1, rv)
         wr(OFS_IRQ_STAT, 32'h1);
         settle(); `CHK("irq clear", 1'b0, IRQ)
      end
      // Looping clip wraps without a gap; wrap event is masked
      clip(3, FMT_LINEAR, 1'b1);
      for (int i = 0; i < 3000 && fetched.size() < 7; i++) @(posedge MCLK);
      ram.mem[base[11:0]] = 8'h5A;
      `CHK("loop count", 1'b1, fetched.size() >= 7)
      for (int i = 0; i < 7; i++) `CHK("wrap", base + AW'(i % 3), fetched[i])
      `CHK("wrap pace", 1'b1, (ft[3] - ft[2]) inside {[208:209]})
      rd(OFS_IRQ_STAT, rv); `CHK("wrap flag", 32'h2, rv & 32'h2)
      `CHK("masked", 1'b0, IRQ)
      wr(OFS_LOOP, 32'h0);
      wait_idle();
      wr(OFS_IRQ_STAT, 32'h3);
      // Empty clip: nothing fetched
      clip(0, FMT_LINEAR, 1'b0);
      settle(); rd(OFS_PLAY, rv); `CHK("empty", 32'h0, rv)
      `CHK("no fetch", 0, fetched.size())
      // Looped constant clip: decoded level at full volume sets the PWM duty
      wr(OFS_VOLUME, 32'h000000FF);
      for (int f = 0; f < 2; f++) begin
         for (int i = 0; i < 3; i++) ram.mem[base[11:0] + 12'(i)] = f ? 8'h80 : 8'h40;
         clip(3, f ? FMT_MULAW : FMT_LINEAR, 1'b1);
         repeat (1200) @(posedge MCLK);
         highs = 0;
         repeat (256) begin
            @(posedge MCLK);
            #1 highs += (AUDIO === 1'b1);
         end
         `CHK("level", f ? 252 : 191, highs)
      end
      wr(OFS_LOOP, 32'h0);
      wait_idle();
      // Muted, idle playback leaves only the synthesizer on the PWM pin
      wr(OFS_VOLUME, 32'h0);
      foreach (notes[k]) begin
         d = xs();
         @(posedge MCLK);
         SYNTH_SAMPLE <= d[7:0];
         repeat (600) @(posedge MCLK);
         highs = 0;
         repeat (256) begin
            @(posedge MCLK);
            #1 highs += (AUDIO === 1'b1);
         end
         `CHK("duty", int'(d[7:0] ^ 8'h80), highs)
      end
      give_verdict();
   end
endmodule
